/* File: src/psc_pkg.sv */
// Purpose: constants for the pseudo-static RAM host port controller
// Assumes: 25 MHz clock (40 ns period), 16-bit data, async RAM on pins
// Notes: all timings are held in their own unit and turned into cycle counts here
package psc_pkg;
   // ----------------------------------------
   // clock and timing figures
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int READ_CYCLE_NS = 70;          // read_cycle_length
   localparam int WRITE_PULSE_NS = 55;         // write_pulse_width, single write
   localparam int WRITE_PULSE_LONG_NS = 70;    // write_pulse_width, long runs
   localparam int LONG_RUN_WRITES = 50;
   localparam int WRITE_RECOVERY_NS = 0;       // write_recovery_time
   localparam int DATA_SETUP_NS = 30;
   localparam int REFRESH_WINDOW_NS = 4000;
   localparam int SUSPEND_NS = 500000;
   localparam int WAKE_NS = 200000;
   // least times round up, at least one cycle
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   // longest times round down
   function automatic int cyc_max(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int READ_CYC = cyc_min(READ_CYCLE_NS);
   localparam int WP_CYC = cyc_min(WRITE_PULSE_NS);
   localparam int WP_LONG_CYC = cyc_min(WRITE_PULSE_LONG_NS);
   localparam int WR_CYC = cyc_min(WRITE_RECOVERY_NS);
   localparam int DSETUP_CYC = cyc_min(DATA_SETUP_NS);
   localparam int REFRESH_CYC = cyc_max(REFRESH_WINDOW_NS);
   localparam int SUSPEND_CYC = cyc_min(SUSPEND_NS);
   localparam int WAKE_CYC = cyc_min(WAKE_NS);
   localparam int CNT_W = 16;
   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      PSC_IDLE = 3'b000,
      PSC_READ = 3'b001,
      PSC_WRITE = 3'b010,
      PSC_RECOV = 3'b011,
      PSC_SLEEP = 3'b100,
      PSC_WAKE = 3'b101,
      PSC_BREAK = 3'b110
   } psc_state_type;
endpackage

/* File: src/psc_timer_if.sv */
// Purpose: carrier between sequencer and its cycle timer
// Assumes: one clock domain
// Notes: load starts a count, done pulses when it expires
`timescale 1ns/10ps
interface psc_timer_if;
   import psc_pkg::*;
   logic load;
   logic [CNT_W+4:0] count;
   logic done;
   modport seq (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

/* File: src/psc_timer.sv */
// Purpose: down counter that times each phase of the pin sequence
// Assumes: load and count come from the sequencer in the same domain
// Notes: done is a one-cycle pulse when the loaded count reaches one
`timescale 1ns/10ps
module psc_timer
   import psc_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // sequencer side
   psc_timer_if.tmr tif
);
   logic [CNT_W+4:0] cnt_ff;

   // ----------------------------------------
   // count down
   // ----------------------------------------
   // done decodes the last count, so a phase loaded with n lasts exactly n cycles
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         cnt_ff <= '0;
      end else if (tif.load) begin
         cnt_ff <= tif.count;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 21'h000001;
      end
   end
   // not gated by load: the sequencer raises load from done, a gate would close a loop
   assign tif.done = (cnt_ff == 21'h000001);
endmodule

/* File: src/psc_host.sv */
// Purpose: host controller driving an asynchronous pseudo-static RAM
// Assumes: user requests are on CLOCK; RAM data returns asynchronously
// Notes: one access at a time; REQ_READY high when a request is taken
`timescale 1ns/10ps
module psc_host
   import psc_pkg::*;
#(
   parameter int ADDR_W = 22,
   parameter int SUSPEND_CYCLES = SUSPEND_CYC,
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int REFRESH_CYCLES = REFRESH_CYC
)
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // user request
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [1:0] REQ_LANES,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [15:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RD_VALID,
   output logic [15:0] RD_DATA,
   // power control
   input wire logic SLEEP_REQ,
   input wire logic WAKE_REQ,
   output logic ASLEEP,
   // memory pins
   output logic PRIMARY_SELECT_N,
   output logic POWER_KEEP_SELECT,
   output logic WRITE_STROBE_N,
   output logic OUTPUT_GATE_N,
   output logic UPPER_LANE_ENABLE_N,
   output logic LOWER_LANE_ENABLE_N,
   output logic [ADDR_W-1:0] ADDR,
   output logic [15:0] DQ_O,
   output logic DQ_OE,
   input wire logic [15:0] DQ_I
);
   psc_timer_if tif();
   psc_timer u_timer (
      .CLOCK(CLOCK),
      .RESET_N(RESET_N),
      .tif(tif)
   );

   psc_state_type state_ff, nxt_state;
   logic [15:0] dq_s1_ff, dq_s2_ff;
   logic [6:0] run_ff;
   logic [CNT_W+4:0] idle_ff;
   logic susp_ok_ff;
   logic dq_sample;
   logic [CNT_W+4:0] nxt_count;
   logic nxt_load;

   // ----------------------------------------
   // data pin synchroniser
   // ----------------------------------------
   // two stages; value is stable by the time it is taken since select is held a full cycle
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         dq_s1_ff <= 16'h0000;
         dq_s2_ff <= 16'h0000;
      end else begin
         dq_s1_ff <= DQ_I;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // write pulse grows to the long minimum once a run exceeds the count
   function automatic logic [CNT_W+4:0] wp_len(input logic [6:0] run);
      return (run >= 7'(LONG_RUN_WRITES)) ? 21'(WP_LONG_CYC) : 21'(WP_CYC);
   endfunction

   always_comb begin
      nxt_state = state_ff;
      nxt_load = 1'b0;
      nxt_count = '0;
      unique case (state_ff)
         PSC_IDLE: begin
            if (SLEEP_REQ) begin
               nxt_state = PSC_SLEEP;
               nxt_load = 1'b1;
               nxt_count = 21'(SUSPEND_CYCLES);
            end else if (idle_ff >= 21'(REFRESH_CYCLES - READ_CYC - 2)) begin
               // standby one full read cycle length before the window closes
               nxt_state = PSC_BREAK;
               nxt_load = 1'b1;
               nxt_count = 21'(READ_CYC);
            end else if (REQ_VALID && REQ_LANES != 2'b00) begin
               nxt_state = REQ_WRITE ? PSC_WRITE : PSC_READ;
               nxt_load = 1'b1;
               // data setup ends before strobe rises, so pulse covers it
               nxt_count = REQ_WRITE ? wp_len(run_ff) : 21'(READ_CYC + 2);
            end
         end
         PSC_READ: if (tif.done) nxt_state = PSC_IDLE;
         PSC_WRITE: if (tif.done) begin
            nxt_state = PSC_RECOV;
            nxt_load = 1'b1;
            nxt_count = 21'(WR_CYC);
         end
         PSC_RECOV: if (tif.done) nxt_state = PSC_IDLE;
         PSC_BREAK: if (tif.done) nxt_state = PSC_IDLE;
         PSC_SLEEP: if (WAKE_REQ && susp_ok_ff) begin
            nxt_state = PSC_WAKE;
            nxt_load = 1'b1;
            nxt_count = 21'(WAKE_CYCLES);
         end
         PSC_WAKE: if (tif.done) nxt_state = PSC_IDLE;
         default: nxt_state = PSC_IDLE;
      endcase
   end
   assign tif.load = nxt_load;
   assign tif.count = nxt_count;

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         state_ff <= PSC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // write run and refresh watch
   // ----------------------------------------
   // run resets after any non-write so isolated writes keep the short pulse
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         run_ff <= 7'h00;
      end else if (state_ff == PSC_IDLE && nxt_state == PSC_WRITE) begin
         if (run_ff != 7'h7f) run_ff <= run_ff + 7'h01;
      end else if (state_ff == PSC_IDLE && nxt_state != PSC_IDLE) begin
         run_ff <= 7'h00;
      end
   end

   // any full read or standby break restarts the 4 us window
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         idle_ff <= '0;
      end else if (state_ff == PSC_READ || state_ff == PSC_BREAK || state_ff == PSC_SLEEP
                   || state_ff == PSC_WAKE) begin
         idle_ff <= '0;
      end else begin
         idle_ff <= idle_ff + 21'h000001;
      end
   end

   // ----------------------------------------
   // suspend wait
   // ----------------------------------------
   // wake is held off until the suspend period has run out; waking earlier would
   // start the power-up sequence while the device may still be entering power-down
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         susp_ok_ff <= 1'b0;
      end else if (state_ff == PSC_SLEEP && tif.done) begin
         susp_ok_ff <= 1'b1;
      end else if (state_ff != PSC_SLEEP) begin
         susp_ok_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   // select and strobe fall together and rise together so the overlap is the pulse
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         PRIMARY_SELECT_N <= 1'b1;
         WRITE_STROBE_N <= 1'b1;
         OUTPUT_GATE_N <= 1'b1;
         UPPER_LANE_ENABLE_N <= 1'b1;
         LOWER_LANE_ENABLE_N <= 1'b1;
         POWER_KEEP_SELECT <= 1'b0;
         ADDR <= '0;
         DQ_O <= 16'h0000;
         DQ_OE <= 1'b0;
      end else begin
         PRIMARY_SELECT_N <= !(nxt_state == PSC_WRITE || nxt_state == PSC_READ);
         WRITE_STROBE_N <= !(nxt_state == PSC_WRITE);
         OUTPUT_GATE_N <= !(nxt_state == PSC_READ);
         // secondary select low only in reset and while asleep; high again begins wake-up
         POWER_KEEP_SELECT <= !(nxt_state == PSC_SLEEP);
         DQ_OE <= (nxt_state == PSC_WRITE);
         if (state_ff == PSC_IDLE && (nxt_state == PSC_WRITE || nxt_state == PSC_READ)) begin
            UPPER_LANE_ENABLE_N <= !REQ_LANES[1];
            LOWER_LANE_ENABLE_N <= !REQ_LANES[0];
            ADDR <= REQ_ADDR;
            DQ_O <= REQ_WDATA;
         end else if (nxt_state == PSC_IDLE || nxt_state == PSC_BREAK) begin
            UPPER_LANE_ENABLE_N <= 1'b1;
            LOWER_LANE_ENABLE_N <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // user side
   // ----------------------------------------
   // read data taken at the end of the cycle; disabled lanes float, so their bytes are forced to zero here
   assign dq_sample = (state_ff == PSC_READ) && tif.done;
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         REQ_READY <= 1'b0;
         RD_VALID <= 1'b0;
         RD_DATA <= 16'h0000;
         ASLEEP <= 1'b0;
      end else begin
         REQ_READY <= state_ff == PSC_IDLE && nxt_state != PSC_IDLE && nxt_state != PSC_SLEEP
                      && nxt_state != PSC_BREAK;
         RD_VALID <= dq_sample;
         if (dq_sample) begin
            RD_DATA <= {UPPER_LANE_ENABLE_N ? 8'h00 : dq_s2_ff[15:8],
                        LOWER_LANE_ENABLE_N ? 8'h00 : dq_s2_ff[7:0]};
         end
         ASLEEP <= (nxt_state == PSC_SLEEP) || (nxt_state == PSC_WAKE);
      end
   end
endmodule

/* File: sim/psc_host_monitor.sv */
// Purpose: pin-level checks on the pseudo-static RAM host controller
// Assumes: bound onto every psc_host instance, one clock domain
// Notes: sees the top-level ports only
`timescale 1ns/10ps
module psc_host_monitor #(
   parameter int WAKE_CYCLES = 20,
   parameter int REFRESH_CYCLES = 40
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // power state
   input wire logic ASLEEP,
   // memory pins
   input wire logic PRIMARY_SELECT_N,
   input wire logic POWER_KEEP_SELECT,
   input wire logic WRITE_STROBE_N,
   input wire logic OUTPUT_GATE_N,
   input wire logic UPPER_LANE_ENABLE_N,
   input wire logic LOWER_LANE_ENABLE_N,
   input wire logic DQ_OE
);
   localparam int WK_HI = WAKE_CYCLES + 2;
   logic [15:0] run_ff;
   logic hi_ff;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   // ----------------------------------------
   // select activity counter
   // ----------------------------------------
   // two idle cycles in a row count as a standby rest and restart the count
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         run_ff <= 16'h0;
         hi_ff <= 1'b0;
      end else begin
         hi_ff <= PRIMARY_SELECT_N;
         run_ff <= (PRIMARY_SELECT_N && hi_ff) ? 16'h0 : run_ff + 16'h1;
      end
   end
   a_write_lanes:
      assert property (!WRITE_STROBE_N |-> !(UPPER_LANE_ENABLE_N && LOWER_LANE_ENABLE_N))
      else $error("write strobe without any lane");
   a_write_frame:
      assert property (!WRITE_STROBE_N |-> !PRIMARY_SELECT_N && DQ_OE)
      else $error("write strobe outside select or data");
   a_pulse_width:
      assert property ($fell(WRITE_STROBE_N) |=> !WRITE_STROBE_N && !PRIMARY_SELECT_N)
      else $error("write pulse too short");
   a_write_end:
      assert property ($rose(WRITE_STROBE_N) |-> PRIMARY_SELECT_N && !DQ_OE
         ##[1:2] (UPPER_LANE_ENABLE_N && LOWER_LANE_ENABLE_N))
      else $error("write end not clean");
   a_refresh_gap:
      assert property (run_ff < REFRESH_CYCLES)
      else $error("select busy too long without rest");
   a_read_len:
      assert property ($fell(OUTPUT_GATE_N) |=> !OUTPUT_GATE_N && !PRIMARY_SELECT_N)
      else $error("read cycle too short");
   a_sleep_quiet:
      assert property (!POWER_KEEP_SELECT && $past(RESET_N) |-> ASLEEP && PRIMARY_SELECT_N)
      else $error("access during power down");
   a_suspend_hold:
      assert property ($fell(POWER_KEEP_SELECT) |-> !POWER_KEEP_SELECT [*8])
      else $error("power-down left before suspend");
   a_wake_hold:
      assert property ($rose(POWER_KEEP_SELECT) && $past(RESET_N, 2) |->
         (ASLEEP && PRIMARY_SELECT_N) [*8] ##[1:WK_HI] !ASLEEP)
      else $error("wake period wrong");
   a_read_gate:
      assert property (!OUTPUT_GATE_N |-> WRITE_STROBE_N && !DQ_OE && !PRIMARY_SELECT_N)
      else $error("gate low while driving");
endmodule
bind psc_host psc_host_monitor #(.WAKE_CYCLES(WAKE_CYCLES), .REFRESH_CYCLES(REFRESH_CYCLES))
   u_mon (.CLOCK(CLOCK), .RESET_N(RESET_N), .ASLEEP(ASLEEP),
   .PRIMARY_SELECT_N(PRIMARY_SELECT_N), .POWER_KEEP_SELECT(POWER_KEEP_SELECT),
   .WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_GATE_N(OUTPUT_GATE_N),
   .UPPER_LANE_ENABLE_N(UPPER_LANE_ENABLE_N), .LOWER_LANE_ENABLE_N(LOWER_LANE_ENABLE_N),
   .DQ_OE(DQ_OE));

/* File: sim/psc_ram_model.sv */
// Purpose: behavioural pseudo-static RAM on the host pins
// Assumes: no clock; 256 words are enough for the bench
// Notes: a floating lane shows the inverted byte, so stale reads never match
`timescale 1ns/10ps
module psc_ram_model #(
   parameter int SUSP_NS = 500000
) (
   // control pins
   input wire logic sel_n,
   input wire logic keep,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic ub_n,
   input wire logic lb_n,
   // address and data
   input wire logic [7:0] addr,
   input wire logic [15:0] din,
   output logic [15:0] dout
);
   logic [15:0] mem [256];
   logic rd_en;
   // ----------------------------------------
   // storage
   // ----------------------------------------
   // level write, stops at whichever of select or strobe rises first
   always @(sel_n, we_n, keep, lb_n, ub_n, addr, din) begin
      if (!sel_n && !we_n && keep) begin
         if (!lb_n) mem[addr][7:0] = din[7:0];
         if (!ub_n) mem[addr][15:8] = din[15:8];
      end
   end
   // contents are lost once the suspend period runs out
   always @(negedge keep) begin
      #(SUSP_NS);
      if (!keep) begin
         foreach (mem[i]) mem[i] = 16'h0;
      end
   end
   // lanes drive only when selected, gated on and enabled
   assign rd_en = !sel_n && keep && !oe_n && we_n;
   assign dout = {(rd_en && !ub_n) ? mem[addr][15:8] : ~mem[addr][15:8],
      (rd_en && !lb_n) ? mem[addr][7:0] : ~mem[addr][7:0]};
endmodule

/* File: sim/tb_psc_host.sv */
// Purpose: self-checking bench for the pseudo-static RAM host controller
// Assumes: small counts shorten sleep, wake and refresh
// Notes: a shadow copy of memory predicts every read
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_psc_host;
   import psc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0, req_write = 1'b0, sleep_req = 1'b0, wake_req = 1'b0;
   logic [1:0] lanes = 2'h0;
   logic [7:0] req_addr = 8'h0, addr;
   logic [15:0] wdata = 16'h0, rd_data, dq_o, ram_q;
   logic [15:0] shm [256];
   logic ready, rd_valid, asleep, sel_n, keep, we_n, oe_n, ub_n, lb_n, dq_oe;
   logic [31:0] seed = 32'habefb0f2;
   int n_mismatch = 0, check_count = 0, k, j;
   wire [15:0] dq_i = dq_oe ? dq_o : ram_q;
   always #20 clk = ~clk;
   psc_host #(.ADDR_W(8), .SUSPEND_CYCLES(20), .WAKE_CYCLES(20), .REFRESH_CYCLES(40)) DUT (
      .CLOCK(clk), .RESET_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
      .REQ_LANES(lanes), .REQ_ADDR(req_addr), .REQ_WDATA(wdata), .REQ_READY(ready),
      .RD_VALID(rd_valid), .RD_DATA(rd_data), .SLEEP_REQ(sleep_req), .WAKE_REQ(wake_req),
      .ASLEEP(asleep), .PRIMARY_SELECT_N(sel_n), .POWER_KEEP_SELECT(keep),
      .WRITE_STROBE_N(we_n), .OUTPUT_GATE_N(oe_n), .UPPER_LANE_ENABLE_N(ub_n),
      .LOWER_LANE_ENABLE_N(lb_n), .ADDR(addr), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i));
   psc_ram_model #(.SUSP_NS(400)) ram (.sel_n(sel_n), .keep(keep), .we_n(we_n),
      .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .addr(addr), .din(dq_i), .dout(ram_q));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // a disabled lane reads back as zero
   function automatic logic [15:0] f_exp(input logic [15:0] v, input logic [1:0] l);
      return v & {{8{l[1]}}, {8{l[0]}}};
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one request held until taken, then the read result is compared
   task automatic access(input logic w, input logic [1:0] l, input logic [7:0] a);
      int i;
      @(posedge clk) #1;
      seed = lfsr(seed);
      {req_write, lanes, req_addr, wdata, req_valid} = {w, l, a, seed[15:0], 1'b1};
      for (i = 0; i < 30 && !ready; i++) @(posedge clk) #1;
      req_valid = 1'b0;
      `CHK(ready, 1'b1);
      if (w) shm[a] = f_exp(seed[15:0], l) | f_exp(shm[a], ~l);
      else begin
         for (i = 0; i < 12 && !rd_valid; i++) @(posedge clk) #1;
         `CHK(rd_valid, 1'b1);
         `CHK(rd_data, f_exp(shm[a], l));
      end
   endtask
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      // every write lane code read back with every read lane code
      for (k = 3; k > 0; k--) begin
         access(1'b1, 2'(k), 8'h05);
         for (j = 1; j < 4; j++) access(1'b0, 2'(j), 8'h05);
      end
      // an empty lane code is never taken
      @(posedge clk) #1;
      {req_valid, lanes} = 3'b100;
      repeat (8) begin
         @(posedge clk) #1;
         `CHK(ready | ~sel_n, 1'b0);
      end
      req_valid = 1'b0;
      // long write run, then random mix
      for (k = 0; k < 60; k++) access(1'b1, 2'h3, 8'(k + 16));
      for (k = 0; k < 60; k++) access(1'b0, 2'h3, 8'(k + 16));
      for (k = 0; k < 80; k++) begin
         seed = lfsr(seed);
         access(seed[0], (seed[2:1] == 2'h0) ? 2'h3 : seed[2:1], 8'(16 + seed[10:3] % 60));
         if (k == 40) repeat (100) @(posedge clk);
      end
      // deep power-down loses contents; wake-up restores access
      @(posedge clk) #1 sleep_req = 1'b1;
      for (k = 0; k < 30 && keep; k++) @(posedge clk) #1;
      sleep_req = 1'b0;
      `CHK(keep, 1'b0);
      repeat (30) @(posedge clk);
      #1 wake_req = 1'b1;
      for (k = 0; k < 60 && asleep; k++) @(posedge clk) #1;
      wake_req = 1'b0;
      `CHK({keep, asleep}, 2'b10);
      foreach (shm[i]) shm[i] = 16'h0;
      access(1'b0, 2'h3, 8'h20);
      access(1'b1, 2'h1, 8'h20);
      access(1'b0, 2'h3, 8'h20);
      report_and_stop();
   end
endmodule
